// ==== adc_ctrl_defines.vh ====
// register offsets, field positions, reset values and timing counts for the converter control
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL 12'h000
`define OFS_MUX 12'h004
`define OFS_STATUS 12'h008
`define OFS_DATA 12'h00C
`define OFS_WIN_LO 12'h010
`define OFS_WIN_HI 12'h014
// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define CTRL_EN_BIT 0
`define CTRL_IE_BIT 1
`define CTRL_WIE_BIT 2
`define CTRL_WIN_OUT_BIT 3
`define CTRL_SW_BIT 4
`define CTRL_TRIG_LSB 8
`define CTRL_TRIG_MSB 10
`define CTRL_RESET 32'h0000_0000
// ----------------------------------------------------------------
// trigger source codes
// ----------------------------------------------------------------
`define TRIG_SW 3'h0
`define TRIG_TMR0 3'h1
`define TRIG_TMR1 3'h2
`define TRIG_TMR2 3'h3
`define TRIG_TMR3 3'h4
`define TRIG_EXT 3'h5
// ----------------------------------------------------------------
// mux fields and status bits
// ----------------------------------------------------------------
`define MUX_POS_LSB 0
`define MUX_NEG_LSB 8
`define STAT_DONE_BIT 0
`define STAT_WIN_BIT 1
`define STAT_BUSY_BIT 2
`define WIN_HI_RESET 10'h3FF
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ 40000000
`define MAX_SPS 200000
`define CONV_CYCLES (`CLK_HZ / `MAX_SPS)
`endif

// ==== adc_seq.v ====
// conversion sequencer: holds one conversion for a fixed slot and hands back the result
`timescale 1ns/1ps
`include "adc_ctrl_defines.vh"
module adc_seq #(
  parameter DATA_W = 10,
  parameter CONV_CYCLES = `CONV_CYCLES
) (
  input wire i_core_clk,
  input wire i_rst_b,
  input wire i_start,
  input wire i_enable,
  input wire [DATA_W-1:0] i_sample,
  output reg o_busy,
  output reg o_done,
  output reg [DATA_W-1:0] o_result
);
  localparam CNT_W = 8;
  reg [CNT_W-1:0] cnt_q;
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= 8'h00;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_result <= {DATA_W{1'b0}};
    end else begin
      o_done <= 1'b0;
      if (!i_enable) begin
        o_busy <= 1'b0; // [R7]
      end else if (!o_busy && i_start) begin
        o_busy <= 1'b1;
        cnt_q <= CONV_CYCLES[CNT_W-1:0] - 8'h01; // [R8]
      end else if (o_busy) begin
        if (cnt_q == 8'h00) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
          o_result <= i_sample; // [R3]
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
      end
    end
  end
endmodule

// ==== adc_ctrl.v ====
// APB-controlled conversion control for the 10-bit successive-approximation converter
//
// Functional notes
// (R1) six trigger sources selectable by software
// (R2) completion flag; interrupt only when enabled
// (R3) latch 10-bit result at each completion
// (R4) window interrupt inside or outside bounds
// (R5) background conversions interrupt only on window
// (R6) separate positive and negative input selections
// (R7) shutdown powers down, blocks conversions
// (R8) back to back up to 200 ksps; the code starts at most every 201 cycles, about 199 ksps
// (R9) external start synchronised then edge detected
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "adc_ctrl_defines.vh"
module adc_ctrl #(
  parameter DATA_W = 10,
  parameter MUX_W = 5
) (
  input wire i_core_clk,
  input wire i_rst_b,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  input wire [3:0] i_tmr_ovf,
  input wire i_ext_convert_start,
  input wire [DATA_W-1:0] i_sar_converter_result,
  output reg o_sar_converter_en,
  output reg o_sar_converter_start,
  output reg [MUX_W-1:0] o_mux_pos,
  output reg [MUX_W-1:0] o_mux_neg,
  output reg o_irq
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [31:0] ctrl_q;
  reg [MUX_W-1:0] pos_q;
  reg [MUX_W-1:0] neg_q;
  reg [DATA_W-1:0] win_lo_q;
  reg [DATA_W-1:0] win_hi_q;
  reg done_q;
  reg win_q;
  reg ext_s1_q;
  reg ext_s2_q;
  reg ext_s3_q;
  reg sw_req_q;
  wire busy;
  wire seq_done;
  wire [DATA_W-1:0] result;
  wire wr_en = i_psel && i_penable && i_pwrite && o_pready;
  wire rd_cyc = i_psel && !i_penable;
  wire acc_first = i_psel && i_penable && !o_pready;
  wire status_wr = wr_en && (i_paddr == `OFS_STATUS);
  reg [31:0] rdata_d;
  reg addr_hit;
  wire [2:0] trig_sel = ctrl_q[`CTRL_TRIG_MSB:`CTRL_TRIG_LSB];
  wire conv_en = ctrl_q[`CTRL_EN_BIT];
  // ----------------------------------------------------------------
  // trigger selection
  // ----------------------------------------------------------------
  // the first stage only feeds the second; edge detect uses stages two and three
  wire ext_edge = ext_s2_q && !ext_s3_q; // [R9]
  reg start_sel;
  always @* begin
    case (trig_sel) // [R1]
      `TRIG_SW: start_sel = sw_req_q;
      `TRIG_TMR0: start_sel = i_tmr_ovf[0];
      `TRIG_TMR1: start_sel = i_tmr_ovf[1];
      `TRIG_TMR2: start_sel = i_tmr_ovf[2];
      `TRIG_TMR3: start_sel = i_tmr_ovf[3];
      `TRIG_EXT: start_sel = ext_edge;
      default: start_sel = 1'b0;
    endcase
  end
  wire start = start_sel && conv_en; // [R7]
  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  adc_seq #(
    .DATA_W(DATA_W)
  ) u_seq (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_start(start),
    .i_enable(conv_en),
    .i_sample(i_sar_converter_result),
    .o_busy(busy),
    .o_done(seq_done),
    .o_result(result)
  );
  // ----------------------------------------------------------------
  // window compare
  // ----------------------------------------------------------------
  wire in_win = (result >= win_lo_q) && (result <= win_hi_q);
  wire win_hit = ctrl_q[`CTRL_WIN_OUT_BIT] ? !in_win : in_win; // [R4]
  reg seq_done_q;
  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  // one decode feeds both data and error, so they cannot disagree
  always @* begin
    addr_hit = 1'b1;
    if (i_paddr == `OFS_CTRL) begin
      rdata_d = ctrl_q;
    end else if (i_paddr == `OFS_MUX) begin
      rdata_d = {19'h0, neg_q, 3'h0, pos_q};
    end else if (i_paddr == `OFS_STATUS) begin
      rdata_d = {29'h0, busy, win_q, done_q};
    end else if (i_paddr == `OFS_DATA) begin
      rdata_d = {22'h0, result}; // [R3]
    end else if (i_paddr == `OFS_WIN_LO) begin
      rdata_d = {22'h0, win_lo_q};
    end else if (i_paddr == `OFS_WIN_HI) begin
      rdata_d = {22'h0, win_hi_q};
    end else begin
      rdata_d = 32'h0000_0000;
      addr_hit = 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // external start synchroniser
  // ----------------------------------------------------------------
  // the pin is asynchronous; nothing but the second stage reads the first
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= i_ext_convert_start; // [R9]
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end
  // ----------------------------------------------------------------
  // bus interface and register writes
  // ----------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_q <= `CTRL_RESET;
      pos_q <= {MUX_W{1'b0}};
      neg_q <= {MUX_W{1'b0}};
      win_lo_q <= {DATA_W{1'b0}};
      win_hi_q <= `WIN_HI_RESET;
      sw_req_q <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      sw_req_q <= 1'b0;
      // one wait state: ready rises in the second access cycle
      o_pready <= acc_first;
      o_pslverr <= 1'b0;
      // data is taken in the setup cycle and held until the next setup
      if (rd_cyc) begin
        o_prdata <= rdata_d;
      end
      // unmapped offsets answer with an error, read zero and ignore writes
      if (acc_first) begin
        o_pslverr <= !addr_hit;
      end
      if (wr_en) begin
        if (i_paddr == `OFS_CTRL) begin
          ctrl_q <= {21'h0, i_pwdata[10:8], 4'h0, i_pwdata[3:0]};
          sw_req_q <= i_pwdata[`CTRL_SW_BIT]; // [R1]
        end else if (i_paddr == `OFS_MUX) begin
          pos_q <= i_pwdata[`MUX_POS_LSB+MUX_W-1:`MUX_POS_LSB]; // [R6]
          neg_q <= i_pwdata[`MUX_NEG_LSB+MUX_W-1:`MUX_NEG_LSB]; // [R6]
        end else if (i_paddr == `OFS_WIN_LO) begin
          win_lo_q <= i_pwdata[DATA_W-1:0];
        end else if (i_paddr == `OFS_WIN_HI) begin
          win_hi_q <= i_pwdata[DATA_W-1:0];
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      done_q <= 1'b0;
      win_q <= 1'b0;
      seq_done_q <= 1'b0;
    end else begin
      seq_done_q <= seq_done;
      // write one to clear; a same-cycle completion wins
      if (seq_done) begin
        done_q <= 1'b1; // [R2]
      end else if (status_wr && i_pwdata[`STAT_DONE_BIT]) begin
        done_q <= 1'b0;
      end
      // window checked one cycle after the result lands
      if (seq_done_q && win_hit) begin
        win_q <= 1'b1; // [R4]
      end else if (status_wr && i_pwdata[`STAT_WIN_BIT]) begin
        win_q <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // converter and interrupt outputs
  // ----------------------------------------------------------------
  // with done interrupt off, background runs quietly unless window hits
  wire irq_d = (done_q && ctrl_q[`CTRL_IE_BIT]) ||
    (win_q && ctrl_q[`CTRL_WIE_BIT]); // [R2] [R5]
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sar_converter_en <= 1'b0;
      o_sar_converter_start <= 1'b0;
      o_mux_pos <= {MUX_W{1'b0}};
      o_mux_neg <= {MUX_W{1'b0}};
      o_irq <= 1'b0;
    end else begin
      o_irq <= irq_d;
      o_sar_converter_en <= conv_en; // [R7]
      o_sar_converter_start <= start && !busy;
      o_mux_pos <= pos_q;
      o_mux_neg <= neg_q;
    end
  end
endmodule

// ==== adc_ctrl_asserts.sv ====
// assertions on the converter control ports
`timescale 1ns/1ps
module adc_ctrl_asserts (
  input wire i_core_clk,
  input wire i_rst_b,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire o_pready,
  input wire o_pslverr,
  input wire o_sar_converter_en,
  input wire o_sar_converter_start,
  input wire [4:0] o_mux_pos,
  input wire [4:0] o_mux_neg,
  input wire o_irq
);
  logic [7:0] gap_q;
  // cycles since the last start, saturating so reset reads as long ago
  always @(posedge i_core_clk or negedge i_rst_b)
    if (!i_rst_b) gap_q <= 8'hFF;
    else if (o_sar_converter_start) gap_q <= 8'h00;
    else if (gap_q != 8'hFF) gap_q <= gap_q + 8'h01;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  a_start_when_on: assert property (o_sar_converter_start |-> o_sar_converter_en)
    else $error("start while shut down");
  a_start_one_cycle: assert property (o_sar_converter_start |=> !o_sar_converter_start)
    else $error("start pulse too long");
  a_start_spacing: assert property (o_sar_converter_start |-> gap_q >= 8'd199)
    else $error("starts too close");
  a_ready_after_access: assert property (o_pready |-> $past(i_psel && i_penable))
    else $error("ready without access");
  a_err_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  a_mux_by_write: assert property (($changed(o_mux_pos) || $changed(o_mux_neg)) |->
    ($past(i_pwrite && i_penable) || $past(i_pwrite && i_penable, 2)))
    else $error("mux changed without write");
  a_power_by_write: assert property ($changed(o_sar_converter_en) |->
    ($past(i_pwrite && i_penable) || $past(i_pwrite && i_penable, 2)))
    else $error("power changed without write");
  a_irq_after_conv: assert property ($rose(o_irq) |-> gap_q >= 8'd200)
    else $error("irq before a conversion ended");
  c_start: cover property (o_sar_converter_start);
  c_irq: cover property ($rose(o_irq));
  c_err: cover property (o_pslverr);
endmodule
bind adc_ctrl adc_ctrl_asserts u_chk (.*);

// ==== sar_model.sv ====
// behavioural converter core: holds the value sampled at each start
`timescale 1ns/1ps
module sar_model (
  input wire i_core_clk,
  input wire i_en,
  input wire i_start,
  input wire [9:0] i_value,
  output wire [9:0] o_result
);
  logic [9:0] held_q;
  always @(posedge i_core_clk)
    if (i_start && i_en) held_q <= i_value;
  // powered down the output is not valid, so show the inverse, not a stale code
  assign o_result = i_en ? held_q : ~held_q;
endmodule

// ==== adc_ctrl_tb.sv ====
// testbench for the converter control block
`timescale 1ns/1ps
`include "adc_ctrl_defines.vh"
module adc_ctrl_tb;
  logic i_core_clk = 0;
  logic i_rst_b = 0;
  logic i_psel = 0;
  logic i_penable = 0;
  logic i_pwrite = 0;
  logic [11:0] i_paddr = 0;
  logic [31:0] i_pwdata = 0;
  logic [3:0] i_tmr_ovf = 0;
  logic i_ext_convert_start = 0;
  logic [9:0] val = 0;
  wire [9:0] i_sar_converter_result;
  wire [31:0] o_prdata;
  wire o_pready, o_pslverr, o_sar_converter_en, o_sar_converter_start, o_irq;
  wire [4:0] o_mux_pos, o_mux_neg;
  int fails = 0, compares = 0, starts = 0, n0;
  logic [31:0] rd, cfg;
  logic err;
  adc_ctrl DUT (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .i_tmr_ovf(i_tmr_ovf),
    .i_ext_convert_start(i_ext_convert_start),
    .i_sar_converter_result(i_sar_converter_result),
    .o_sar_converter_en(o_sar_converter_en),
    .o_sar_converter_start(o_sar_converter_start),
    .o_mux_pos(o_mux_pos),
    .o_mux_neg(o_mux_neg),
    .o_irq(o_irq)
  );
  sar_model u_sar (.i_core_clk(i_core_clk), .i_en(o_sar_converter_en),
    .i_start(o_sar_converter_start), .i_value(val), .o_result(i_sar_converter_result));
  initial forever #12.5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) if (o_sar_converter_start) starts <= starts + 1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_psel <= 1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1;
    @(posedge i_core_clk);
    while (o_pready !== 1'b1) @(posedge i_core_clk);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
  endtask
  task automatic conv(input logic [2:0] t, input logic [9:0] v, input logic ei);
    n0 = starts;
    val <= v;
    apb(1, `OFS_CTRL, cfg | (t << 8) | ((t == 0) ? 16 : 0));
    if (t >= 1 && t <= 4) begin
      i_tmr_ovf <= 4'h1 << (t - 1);
      @(posedge i_core_clk);
      i_tmr_ovf <= 0;
    end
    // a software start is under way by the time this read samples status
    if (t == 0) begin
      apb(0, `OFS_STATUS, 0);
      chk(rd[2], 1);
    end
    // the pin stays high through the whole slot: one edge, one conversion
    i_ext_convert_start <= (t == 5);
    repeat (220) @(posedge i_core_clk);
    i_ext_convert_start <= 0;
    chk(starts - n0, 1);
    apb(0, `OFS_DATA, 0);
    chk(rd, v);
    apb(0, `OFS_STATUS, 0);
    chk(rd[0], 1);
    chk(rd[1], cfg[2] ? ei : 1'b1);
    chk(o_irq, ei);
    chk(o_sar_converter_en, 1);
    apb(1, `OFS_STATUS, 3);
  endtask
  task automatic close_out;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_core_clk);
    fails++;
    close_out;
  end
  initial begin
    repeat (10) @(posedge i_core_clk);
    i_rst_b <= 1;
    apb(0, `OFS_CTRL, 0);
    chk(rd, `CTRL_RESET);
    apb(0, `OFS_WIN_HI, 0);
    chk(rd, 32'h0000_03FF);
    apb(0, 12'h018, 0);
    chk(err, 1);
    chk(rd, 0);
    apb(1, `OFS_CTRL, 32'h0000_0110);
    i_tmr_ovf <= 4'h1;
    @(posedge i_core_clk);
    i_tmr_ovf <= 0;
    repeat (250) @(posedge i_core_clk);
    chk(starts, 0);
    chk(o_sar_converter_en, 0);
    apb(1, `OFS_MUX, 32'h0000_0314);
    repeat (2) @(posedge i_core_clk);
    chk(o_mux_pos, 20);
    chk(o_mux_neg, 3);
    cfg = 3;
    for (int t = 0; t < 6; t++) conv(t, 10'h3FF - t, 1);
    cfg = 1;
    conv(1, 10'h000, 0);
    apb(1, `OFS_WIN_LO, 100);
    apb(1, `OFS_WIN_HI, 200);
    // bounds are inclusive, so probe just on each edge and just past the upper one
    cfg = 5;
    conv(2, 10'd100, 1);
    conv(2, 10'd201, 0);
    cfg = 13;
    conv(3, 10'd201, 1);
    conv(3, 10'd200, 0);
    apb(1, `OFS_CTRL, 32'h0000_0101);
    n0 = starts;
    repeat (420) begin
      i_tmr_ovf <= 4'h1;
      @(posedge i_core_clk);
      i_tmr_ovf <= 0;
      @(posedge i_core_clk);
    end
    chk(starts - n0 >= 4 && starts - n0 <= 5, 1);
    close_out;
  end
endmodule
